//--- src/dac_port_pkg.sv
// Shared constants and types for the dual converter input port and its
// control-word decoder.
// Assumes a single 25 MHz system clock; all figures below are in its terms.
package dac_port_pkg;

    // Sample word width on each channel bus.
    localparam int DATA_W = 10;

    // Control-word field positions on the channel A bus.
    localparam int PWRDN_BIT = 9;
    localparam int EN_BIT    = 8;
    localparam int F2_BIT    = 7;
    localparam int F1_BIT    = 6;
    localparam int GAIN_MSB  = 5;
    localparam int GAIN_LSB  = 2;
    localparam int GAIN_W    = GAIN_MSB - GAIN_LSB + 1;

    // Values after reset.
    localparam logic [GAIN_W-1:0] GAIN_RST = 4'h0;

    // Depth of the sample pair buffer.
    localparam int BUF_DEPTH = 2;

    // Lock detection: edges needed and the longest allowed gap.
    localparam logic [3:0] LOCK_EDGES    = 4'h8;
    localparam int         CLK_PERIOD_NS = 40;
    localparam int         LOCK_GAP_NS   = 400;
    localparam logic [7:0] LOCK_GAP_CYC  =
        8'(LOCK_GAP_NS / CLK_PERIOD_NS);

    // Converter power state.
    typedef enum logic [1:0] {
        PWR_STANDBY,
        PWR_ON,
        PWR_DOWN
    } power_mode_t;

    // Interpolation ratio.
    typedef enum logic [1:0] {
        INTERP_1X,
        INTERP_2X,
        INTERP_4X
    } interp_t;

    // Lock detector states.
    typedef enum logic [1:0] {
        LOCK_IDLE,
        LOCK_ACQ,
        LOCK_HELD
    } lock_state_t;

    // Interpolation ratio from the two filter enable bits.
    function automatic interp_t decode_interp(input logic f2,
                                              input logic f1);
        if (f2) begin
            return INTERP_4X;
        end
        return f1 ? INTERP_2X : INTERP_1X;
    endfunction : decode_interp

endpackage : dac_port_pkg

//--- src/pair_buffer.sv
// Small FIFO of sample pairs with valid and ready on both sides.
// Assumes one clock; the drain side may stall for any number of cycles.
`timescale 1ns/1ps
module pair_buffer
    import dac_port_pkg::*;
#(
    parameter int W     = 2 * DATA_W,
    parameter int DEPTH = BUF_DEPTH
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         sys_rst,
    // Fill side.
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side.
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int OW = $clog2(DEPTH + 1); // Occupancy count width.

    logic [W-1:0]  mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] wr_ptr_nxt;
    logic [AW-1:0] rd_ptr_r;
    logic [AW-1:0] rd_ptr_nxt;
    logic [OW-1:0] count_r;
    logic [OW-1:0] count_nxt;
    logic          push;
    logic          pop;

    // Next pointer value with wrap at the buffer depth.
    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction : bump

    // Full and empty come straight from the occupancy count.
    assign in_ready  = (count_r != OW'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data  = mem_r[rd_ptr_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer and count updates.
    always_comb begin
        wr_ptr_nxt = push ? bump(wr_ptr_r) : wr_ptr_r;
        rd_ptr_nxt = pop ? bump(rd_ptr_r) : rd_ptr_r;
        count_nxt  = count_r;
        if (push && !pop) begin
            count_nxt = OW'(count_r + 1'b1);
        end else if (pop && !push) begin
            count_nxt = OW'(count_r - 1'b1);
        end
    end

    // Registers the pointers and writes the storage.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r  <= count_nxt;
            if (push) begin
                mem_r[wr_ptr_r] <= in_data;
            end
        end
    end

endmodule : pair_buffer

//--- src/dac_input_port.sv
// Input port of a dual 10-bit converter with its control-word decoder.
// Assumes all pins are synchronous to clk; the clock pin is sampled, not
// used as a clock.
//
// Overview of operation
// R1 - Power-down bit forces full power-down mode
// R2 - Converter-on bit picks standby or powered up
// R3 - Second filter bit selects 4x interpolation
// R4 - Second filter clear: first filter decides
// R5 - First filter bit: off or 2x
// R6 - Bits 5 to 2 form gain trim
// R7 - Clock pin input when PLL on, else output
// R8 - Interleave high: both channels from port A
// R9 - Channel A word captured on clock rise
// R10 - Channel B word captured on clock fall
// R11 - Channel A word ten bits, bit 9 MSB
// R12 - Channel B word ten bits, bit 9 MSB
// R13 - Control word latched on strobe falling edge
// R14 - PLL enabled while enable input high
// R15 - Lock output high while PLL locked
// R16 - Output register updates on following rising edge
// R17 - Host interleaves A on rise, B on fall
`timescale 1ns/1ps
module dac_input_port
    import dac_port_pkg::*;
(
    // Clock and reset.
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // Sample buses and mode.
    input  wire logic [DATA_W-1:0] chan_a_sample_bus,
    input  wire logic [DATA_W-1:0] chan_b_sample_bus,
    input  wire logic              interleave_select,
    // Control strobe and PLL enable.
    input  wire logic              ctrl_write_strobe_n,
    input  wire logic              pll_on_input,
    // Two-way clock pin.
    input  wire logic              clk_pin_in,
    output logic                   clk_pin_out,
    output logic                   clk_pin_oe,
    // Decoded control and status.
    output power_mode_t            power_mode,
    output interp_t                interp_mode,
    output logic [GAIN_W-1:0]      chan_a_gain_trim,
    output logic                   filter_conflict,
    output logic                   pll_lock,
    output logic                   sample_overrun,
    // Converter sample stream.
    output logic                   sample_ready,
    output logic                   conv_valid,
    input  wire logic              conv_ready,
    output logic [DATA_W-1:0]      conv_a,
    output logic [DATA_W-1:0]      conv_b
);
    localparam int PW = 2 * DATA_W;

    // Clock pin direction, divider and edge detection.
    logic              oe_r;
    logic              oe_nxt;
    logic              div_r;
    logic              div_nxt;
    logic              lvl_prev_r;
    logic              pin_lvl;
    logic              pin_rise;
    logic              pin_fall;
    // Control strobe and decoded control.
    logic              stb_prev_r;
    logic              stb_fall;
    power_mode_t       mode_r;
    power_mode_t       mode_nxt;
    interp_t           interp_r;
    interp_t           interp_nxt;
    logic [GAIN_W-1:0] gain_r;
    logic [GAIN_W-1:0] gain_nxt;
    logic              conflict_r;
    logic              conflict_nxt;
    // Sample capture and buffering.
    logic [DATA_W-1:0] a_hold_r;
    logic [DATA_W-1:0] a_hold_nxt;
    logic [DATA_W-1:0] b_word;
    logic              buf_in_ready;
    logic              buf_out_valid;
    logic              buf_out_ready;
    logic [PW-1:0]     buf_in_data;
    logic [PW-1:0]     buf_out_data;
    logic              push_req;
    logic              overrun_r;
    logic              overrun_nxt;
    logic              ready_r;
    // Converter output register.
    logic              cv_r;
    logic              cv_nxt;
    logic [DATA_W-1:0] ca_r;
    logic [DATA_W-1:0] ca_nxt;
    logic [DATA_W-1:0] cb_r;
    logic [DATA_W-1:0] cb_nxt;
    // Lock detector.
    lock_state_t       lk_r;
    lock_state_t       lk_nxt;
    logic [3:0]        edges_r;
    logic [3:0]        edges_nxt;
    logic [7:0]        gap_r;
    logic [7:0]        gap_nxt;
    logic              lock_r;
    logic              lock_nxt;

    // The pin drives the divided clock only while the PLL is off; with the
    // PLL on the host clock arrives on the same pin.
    always_comb begin
        oe_nxt  = !pll_on_input;                        // R7 R14
        div_nxt = oe_r ? !div_r : 1'b0;
    end

    // The level seen is our own drive or the sampled pin.
    assign pin_lvl  = oe_r ? div_r : clk_pin_in;
    assign pin_rise = pin_lvl && !lvl_prev_r;
    assign pin_fall = !pin_lvl && lvl_prev_r;
    assign stb_fall = !ctrl_write_strobe_n && stb_prev_r;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            oe_r       <= 1'b1;
            div_r      <= 1'b0;
            lvl_prev_r <= 1'b0;
            stb_prev_r <= 1'b1;
        end else begin
            oe_r       <= oe_nxt;
            div_r      <= div_nxt;
            lvl_prev_r <= pin_lvl;
            stb_prev_r <= ctrl_write_strobe_n;
        end
    end
    // Control word decode, latched on the strobe falling edge only.
    always_comb begin
        mode_nxt     = mode_r;
        interp_nxt   = interp_r;
        gain_nxt     = gain_r;
        conflict_nxt = conflict_r;
        if (stb_fall) begin                             // R13
            if (chan_a_sample_bus[PWRDN_BIT]) begin
                mode_nxt = PWR_DOWN;                    // R1
            end else if (chan_a_sample_bus[EN_BIT]) begin
                mode_nxt = PWR_ON;                      // R2
            end else begin
                mode_nxt = PWR_STANDBY;                 // R2
            end
            interp_nxt   = decode_interp(chan_a_sample_bus[F2_BIT], // R3 R4 R5
                                         chan_a_sample_bus[F1_BIT]);
            gain_nxt     = chan_a_sample_bus[GAIN_MSB:GAIN_LSB]; // R6
            // Flags a host that asks for 4x without the first filter.
            conflict_nxt = chan_a_sample_bus[F2_BIT]
                           && !chan_a_sample_bus[F1_BIT]; // R3
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_r     <= PWR_STANDBY;
            interp_r   <= INTERP_1X;
            gain_r     <= GAIN_RST;
            conflict_r <= 1'b0;
        end else begin
            mode_r     <= mode_nxt;
            interp_r   <= interp_nxt;
            gain_r     <= gain_nxt;
            conflict_r <= conflict_nxt;
        end
    end

    // Channel A is held from the rising edge; the pair is formed at the
    // falling edge with channel B from its own bus or, when interleaved,
    // from port A.
    always_comb begin
        a_hold_nxt = pin_rise ? chan_a_sample_bus : a_hold_r; // R9 R11
        b_word     = interleave_select ? chan_a_sample_bus   // R8 R17
                                       : chan_b_sample_bus;  // R10 R12
        push_req   = pin_fall;                               // R10
        // A pair that finds the buffer full is lost; the flag stays set
        // until the next control write, and a new loss wins over it.
        overrun_nxt = (overrun_r && !stb_fall) ||
                      (push_req && !buf_in_ready);
    end
    assign buf_in_data = {a_hold_r, b_word};

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            a_hold_r  <= '0;
            overrun_r <= 1'b0;
            ready_r   <= 1'b0;
        end else begin
            a_hold_r  <= a_hold_nxt;
            overrun_r <= overrun_nxt;
            ready_r   <= buf_in_ready;
        end
    end

    // Two-entry buffer so a converter stage stalled for up to two pairs loses none.
    pair_buffer #(
        .W     (PW),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (push_req),
        .in_ready  (buf_in_ready),
        .in_data   (buf_in_data),
        .out_valid (buf_out_valid),
        .out_ready (buf_out_ready),
        .out_data  (buf_out_data)
    );

    // The output register takes a buffered pair on the next rising edge,
    // provided the stage is empty or being emptied.
    assign buf_out_ready = pin_rise && (!cv_r || conv_ready); // R16

    always_comb begin
        cv_nxt = cv_r;
        ca_nxt = ca_r;
        cb_nxt = cb_r;
        if (buf_out_valid && buf_out_ready) begin
            cv_nxt = 1'b1;                                    // R16
            ca_nxt = buf_out_data[PW-1:DATA_W];
            cb_nxt = buf_out_data[DATA_W-1:0];
        end else if (cv_r && conv_ready) begin
            cv_nxt = 1'b0;
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cv_r <= 1'b0;
            ca_r <= '0;
            cb_r <= '0;
        end else begin
            cv_r <= cv_nxt;
            ca_r <= ca_nxt;
            cb_r <= cb_nxt;
        end
    end

    // Lock detector: enough rising edges on the pin with no long gap.
    // A gap of LOCK_GAP_CYC cycles or a disabled PLL drops lock at once.
    always_comb begin
        lk_nxt    = lk_r;
        edges_nxt = edges_r;
        gap_nxt   = pin_rise ? 8'h00 : 8'(gap_r + 8'h01);
        case (lk_r)
            LOCK_IDLE: begin
                edges_nxt = 4'h0;
                if (pll_on_input && pin_rise) begin
                    lk_nxt = LOCK_ACQ;
                end
            end
            LOCK_ACQ: begin
                if (pin_rise) begin
                    edges_nxt = 4'(edges_r + 4'h1);
                end
                if (edges_r == LOCK_EDGES) begin
                    lk_nxt = LOCK_HELD;
                end
            end
            LOCK_HELD: begin
                lk_nxt = LOCK_HELD;
            end
            default: begin
                lk_nxt = LOCK_IDLE;
            end
        endcase
        if (!pll_on_input || gap_r >= LOCK_GAP_CYC) begin    // R14
            lk_nxt  = LOCK_IDLE;
            gap_nxt = 8'h00;
        end
        lock_nxt = (lk_nxt == LOCK_HELD);                     // R15
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lk_r    <= LOCK_IDLE;
            edges_r <= 4'h0;
            gap_r   <= 8'h00;
            lock_r  <= 1'b0;
        end else begin
            lk_r    <= lk_nxt;
            edges_r <= edges_nxt;
            gap_r   <= gap_nxt;
            lock_r  <= lock_nxt;
        end
    end

    // Every output is a flip-flop.
    assign clk_pin_out      = div_r;
    assign clk_pin_oe       = oe_r;
    assign power_mode       = mode_r;
    assign interp_mode      = interp_r;
    assign chan_a_gain_trim = gain_r;
    assign filter_conflict  = conflict_r;
    assign pll_lock         = lock_r;
    assign sample_overrun   = overrun_r;
    assign sample_ready     = ready_r;
    assign conv_valid       = cv_r;
    assign conv_a           = ca_r;
    assign conv_b           = cb_r;
    // Checks on the decoded control, the pin and the data path.
    pwr_down_a: assert property (@(posedge clk) disable iff (sys_rst) // R1
        stb_fall && chan_a_sample_bus[PWRDN_BIT] |=> power_mode == PWR_DOWN)
        else $error("power-down bit did not enter power-down");
    standby_a: assert property (@(posedge clk) disable iff (sys_rst) // R2
        stb_fall && !chan_a_sample_bus[PWRDN_BIT] |=>
        power_mode == ($past(chan_a_sample_bus[EN_BIT]) ? PWR_ON
                                                         : PWR_STANDBY))
        else $error("converter-on bit decoded wrongly");
    four_x_a: assert property (@(posedge clk) disable iff (sys_rst) // R3
        stb_fall && chan_a_sample_bus[F2_BIT] |=> interp_mode == INTERP_4X)
        else $error("second filter bit did not select 4x");
    first_filter_a: assert property (@(posedge clk) disable iff (sys_rst) // R4
        stb_fall && !chan_a_sample_bus[F2_BIT] |=>
        interp_mode == ($past(chan_a_sample_bus[F1_BIT]) ? INTERP_2X
                                                          : INTERP_1X))
        else $error("first filter bit decoded wrongly");
    gain_field_a: assert property (@(posedge clk) disable iff (sys_rst) // R6
        stb_fall |=> chan_a_gain_trim ==
        $past(chan_a_sample_bus[GAIN_MSB:GAIN_LSB]))
        else $error("gain trim not taken from bits 5 to 2");
    hold_ctrl_a: assert property (@(posedge clk) disable iff (sys_rst) // R13
        !stb_fall |=> $stable(chan_a_gain_trim) && $stable(power_mode)
                      && $stable(interp_mode))
        else $error("control changed without a strobe fall");
    pin_dir_a: assert property (@(posedge clk) disable iff (sys_rst) // R7
        ##1 clk_pin_oe == !$past(pll_on_input))
        else $error("clock pin direction wrong for PLL state");
    no_lock_a: assert property (@(posedge clk) disable iff (sys_rst) // R15
        !pll_on_input |=> !pll_lock)
        else $error("lock shown with PLL disabled");
    chan_a_cap_a: assert property (@(posedge clk) disable iff (sys_rst) // R9
        pin_rise |=> a_hold_r == $past(chan_a_sample_bus))
        else $error("channel A not captured on rising edge");
    chan_b_src_a: assert property (@(posedge clk) disable iff (sys_rst) // R8
        push_req |-> buf_in_data[DATA_W-1:0] == (interleave_select
                     ? chan_a_sample_bus : chan_b_sample_bus))
        else $error("channel B word taken from the wrong bus");
    out_update_a: assert property (@(posedge clk) disable iff (sys_rst) // R16
        $rose(conv_valid) |-> $past(pin_rise))
        else $error("output register updated off a rising edge");

endmodule : dac_input_port

//--- testbench/host_model.sv
// Host data source model that feeds sample pairs to the converter port.
// Assumes pin_level is the clock pin level the port samples on each clk.
`timescale 1ns/1ps
module host_model
    import dac_port_pkg::*;
(
    // Clock and reset.
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // Observed clock pin level and mode.
    input  wire logic              pin_level,
    input  wire logic              interleave_select,
    // Sample buses towards the port.
    output logic [DATA_W-1:0]      host_a,
    output logic [DATA_W-1:0]      host_b
);
    logic              lvl_r;
    logic [DATA_W-1:0] idx_r;
    logic [DATA_W-1:0] wa;
    logic [DATA_W-1:0] wb;

    // Pair index steps after each pin fall, when the port takes the pair.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lvl_r <= 1'b0;
            idx_r <= 10'h000;
        end else begin
            lvl_r <= pin_level;
            if (!pin_level && lvl_r) begin
                idx_r <= idx_r + 10'h001;
            end
        end
    end

    // Words of a pair; B is A bit-reversed and XORed with 10'h0f3 so order shows.
    always_comb begin
        wa = idx_r ^ 10'h2a5;
        for (int i = 0; i < DATA_W; i++) begin
            wb[i] = wa[DATA_W-1-i];
        end
        wb = wb ^ 10'h0f3;
    end

    // Words are valid only in their own pin phase; elsewhere inverted.
    always_comb begin
        host_a = pin_level ? wa : (interleave_select ? wb : ~wa);
        // In interleave mode port B carries junk, so only port A can pass.
        host_b = (pin_level || interleave_select) ? ~wb : wb;
    end

endmodule : host_model

//--- testbench/testbench.sv
// Self-checking bench for the dual converter input port.
// Assumes host_model on the sample buses and a bench-driven consumer.
`timescale 1ns/1ps
module testbench;
    import dac_port_pkg::*;

    logic clk = 1'b0, sys_rst = 1'b1, interleave_select = 1'b0;
    logic ctrl_write_strobe_n = 1'b1, pll_on_input = 1'b0;
    logic clk_pin_in = 1'b0, conv_ready = 1'b1, ctl_on = 1'b0;
    logic clk_pin_out, clk_pin_oe, filter_conflict, pll_lock;
    logic sample_overrun, sample_ready, conv_valid, pin_level, contig;
    logic [DATA_W-1:0] ctl_word = 10'h000, host_a, host_b, idx, b0;
    logic [DATA_W-1:0] chan_a_sample_bus, conv_a, conv_b;
    logic [GAIN_W-1:0] chan_a_gain_trim;
    power_mode_t       power_mode;
    interp_t           interp_mode;
    int failures = 0, tests_run = 0, rx = 0, last_idx = -1, cyc = 0;

    // Pin level from whichever party drives it; port A shared with control.
    assign pin_level = clk_pin_oe ? clk_pin_out : clk_pin_in;
    assign chan_a_sample_bus = ctl_on ? ctl_word : host_a;

    dac_input_port u_dac_input_port (
        .clk(clk), .sys_rst(sys_rst), .chan_a_sample_bus(chan_a_sample_bus),
        .chan_b_sample_bus(host_b), .interleave_select(interleave_select),
        .ctrl_write_strobe_n(ctrl_write_strobe_n),
        .pll_on_input(pll_on_input), .clk_pin_in(clk_pin_in),
        .clk_pin_out(clk_pin_out), .clk_pin_oe(clk_pin_oe),
        .power_mode(power_mode), .interp_mode(interp_mode),
        .chan_a_gain_trim(chan_a_gain_trim),
        .filter_conflict(filter_conflict), .pll_lock(pll_lock),
        .sample_overrun(sample_overrun), .sample_ready(sample_ready),
        .conv_valid(conv_valid), .conv_ready(conv_ready),
        .conv_a(conv_a), .conv_b(conv_b));

    host_model u_host_model (
        .clk(clk), .sys_rst(sys_rst), .pin_level(pin_level),
        .interleave_select(interleave_select), .host_a(host_a),
        .host_b(host_b));

    // Free-running system clock.
    always #20 clk = ~clk;

    task automatic end_of_test;
        if (failures == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk_word(input logic [DATA_W-1:0] got, exp,
                            input string m);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, exp, input string m);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t %s got %b exp %b", $time, m, got, exp);
        end
    endtask : chk_bit

    function automatic logic [DATA_W-1:0] exp_b(input logic [DATA_W-1:0] a);
        for (int i = 0; i < DATA_W; i++) begin
            exp_b[i] = a[DATA_W-1-i];
        end
        return exp_b ^ 10'h0f3;
    endfunction : exp_b

    function automatic power_mode_t exp_pwr(input logic [DATA_W-1:0] w);
        if (w[9]) return PWR_DOWN;
        return w[8] ? PWR_ON : PWR_STANDBY;
    endfunction : exp_pwr

    function automatic interp_t exp_int(input logic [DATA_W-1:0] w);
        if (w[7]) return INTERP_4X;
        return w[6] ? INTERP_2X : INTERP_1X;
    endfunction : exp_int

    // Compares every decoded field with what word w should give.
    task automatic chk_ctl(input logic [DATA_W-1:0] w);
        chk_word(10'(power_mode), 10'(exp_pwr(w)), "power");
        chk_word(10'(interp_mode), 10'(exp_int(w)), "interp");
        chk_word(10'(chan_a_gain_trim), 10'(w[5:2]), "gain");
        chk_bit(filter_conflict, w[7] & ~w[6], "conflict");
    endtask : chk_ctl

    // One strobe pulse; the bus shows the inverse once the strobe is high.
    task automatic ctl_write(input logic [DATA_W-1:0] w);
        @(posedge clk);
        ctrl_write_strobe_n <= 1'b0;
        ctl_on <= 1'b1;
        ctl_word <= w;
        @(posedge clk);
        ctrl_write_strobe_n <= 1'b1;
        ctl_word <= ~w;
        @(posedge clk);
        ctl_on <= 1'b0;
        @(posedge clk);
        #1;
        chk_ctl(w);
    endtask : ctl_write

    // Checks every pair the consumer takes, contents and order.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            end_of_test();
        end
        if (!sys_rst && conv_valid === 1'b1 && conv_ready === 1'b1) begin
            idx = conv_a ^ 10'h2a5;
            chk_word(conv_b, exp_b(conv_a), "pair b word");
            if (last_idx >= 0 && contig) begin
                chk_word(idx, 10'(last_idx + 1), "pair order");
            end else if (last_idx >= 0) begin
                chk_bit(idx > 10'(last_idx), 1'b1, "pair order");
            end
            last_idx = int'(idx);
            rx++;
        end
    end

    initial begin
        void'($urandom(32'h5c327d21));
        contig = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk_word(10'(power_mode), 10'(PWR_STANDBY), "reset power");
        chk_word(10'(interp_mode), 10'(INTERP_1X), "reset interp");
        chk_bit(conv_valid, 1'b0, "reset valid");
        @(posedge clk);
        sys_rst <= 1'b0;
        // Own clock on the pin, consumer never stalls.
        repeat (200) @(posedge clk);
        #1;
        b0[0] = clk_pin_out;
        chk_bit(clk_pin_oe, 1'b1, "pin drive");
        chk_bit(rx > 80, 1'b1, "stream rate");
        chk_bit(sample_ready, 1'b1, "room");
        @(posedge clk);
        #1;
        chk_bit(clk_pin_out, ~b0[0], "pin toggle");
        @(posedge clk);
        interleave_select <= 1'b1;
        repeat (100) @(posedge clk);
        // Stall until the buffer refuses, then drain at random.
        contig <= 1'b0;
        conv_ready <= 1'b0;
        repeat (20) @(posedge clk);
        #1;
        chk_bit(sample_overrun, 1'b1, "overrun");
        chk_bit(sample_ready, 1'b0, "full");
        chk_bit(conv_valid, 1'b1, "held pair");
        repeat (200) begin
            @(posedge clk);
            conv_ready <= 1'($urandom);
            interleave_select <= 1'($urandom);
        end
        // External clock on the pin with the PLL on.
        @(posedge clk);
        conv_ready <= 1'b1;
        pll_on_input <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk_bit(clk_pin_oe, 1'b0, "pin input");
        repeat (12) begin
            repeat (2) @(posedge clk);
            clk_pin_in <= 1'b1;
            repeat (2) @(posedge clk);
            clk_pin_in <= 1'b0;
        end
        @(posedge clk);
        #1;
        chk_bit(pll_lock, 1'b1, "lock");
        repeat (14) @(posedge clk);
        #1;
        chk_bit(pll_lock, 1'b0, "lock lost");
        chk_bit(conv_valid, 1'b0, "drained");
        // Control words with the pin idle: all mode bits, then random.
        for (int i = 0; i < 16; i++) begin
            ctl_write({4'(i), 4'($urandom), 2'($urandom)});
            chk_bit(sample_overrun, 1'b0, "overrun clear");
        end
        repeat (16) ctl_write(10'($urandom));
        // A strobe held low takes only the word present at its fall.
        @(posedge clk);
        ctrl_write_strobe_n <= 1'b0;
        ctl_on <= 1'b1;
        ctl_word <= 10'h2bc;
        repeat (2) @(posedge clk);
        ctl_word <= 10'h0c0;
        repeat (3) @(posedge clk);
        #1;
        chk_ctl(10'h2bc);
        @(posedge clk);
        ctrl_write_strobe_n <= 1'b1;
        ctl_on <= 1'b0;
        pll_on_input <= 1'b0;
        repeat (100) @(posedge clk);
        #1;
        chk_bit(clk_pin_oe, 1'b1, "pin drive again");
        chk_bit(pll_lock, 1'b0, "no lock");
        end_of_test();
    end

endmodule : testbench
